// >>> src/etr_pkg.sv
// Package for the emulated target reset control block
// Notes on behaviour
// - Emulator reset and emulated-core reset are separate; neither asserts the other.
// - Core reset is accepted while running and while halted, per source gating.
// - Back-panel target reset button resets the core only while running.
// - Pod reset button resets the core only while running.
// - Host reset command resets the core once ready, running or halted, and halts it if running.
// - Target board reset resets the core only while running.
// - Only target-board resets drive the target reset net; others stay internal.
// - For the special part, external reset needs the host enable option.
// - Emulator reset clears program memory; host must reload the image.
// - Emulator reset drops ready; ready returns only after reinitialisation completes.
// - After power-up, supply-present shows at once; ready follows init and self-test.
package etr_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEBOUNCE_US = 10;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
  localparam int CORE_RST_CYCLES = 16;
  localparam int INIT_CYCLES = 65536;
  localparam int CNT_W = 20;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ETR_ST_RESET = 2'b00,
    ETR_ST_CLEAR = 2'b01,
    ETR_ST_TEST = 2'b11,
    ETR_ST_READY = 2'b10
  } etr_state_t;

  typedef struct packed {
    logic panel_button;
    logic pod_button;
    logic target_board;
  } etr_pins_t;

endpackage

// >>> src/etr_debounce.sv
// Synchroniser and debouncer for one asynchronous reset source
`timescale 1ns/1ps
module etr_debounce import etr_pkg::*; #(
  parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_raw,
  output logic o_level,
  output logic o_rise
);
  logic meta_reg;
  logic sync_reg;
  logic level_reg;
  logic rise_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  wire logic differs = sync_reg != level_reg;
  wire logic settled = cnt_reg >= CNT_W'(STABLE_CYCLES - 1);

  assign cnt_next = (differs && !settled) ? cnt_reg + CNT_W'(1) : '0;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      meta_reg <= i_raw;
      sync_reg <= meta_reg;
      cnt_reg <= cnt_next;
      if (differs && settled) begin
        level_reg <= sync_reg;
      end
      rise_reg <= differs && settled && sync_reg;
    end
  end

  assign o_level = level_reg;
  assign o_rise = rise_reg;
endmodule

// >>> src/etr_reset_ctrl.sv
// Top of the emulated target reset control block
`timescale 1ns/1ps
module etr_reset_ctrl import etr_pkg::*; #(
  parameter int INIT_LEN = INIT_CYCLES,
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
  parameter int CORE_RST_LEN = CORE_RST_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_emu_reset_button,
  input wire logic i_back_panel_target_reset_button,
  input wire logic i_pod_reset_button,
  input wire logic i_target_reset,
  input wire logic i_host_reset_cmd,
  input wire logic i_host_ext_reset_en,
  input wire logic i_ext_reset_gated_part,
  input wire logic i_core_running,
  input wire logic i_self_test_pass,
  output logic o_supply_ok,
  output logic o_ready,
  output logic o_prog_mem_clear,
  output logic o_core_reset,
  output logic o_core_halt,
  output logic o_target_reset_out,
  output logic o_target_reset_oe
);
  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  etr_pins_t raw;
  etr_pins_t rise;
  etr_pins_t level;
  logic emu_btn_rise;

  assign raw = '{panel_button: i_back_panel_target_reset_button,
                 pod_button: i_pod_reset_button,
                 target_board: i_target_reset};

  etr_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_db_panel (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_raw(raw.panel_button),
    .o_level(level.panel_button),
    .o_rise(rise.panel_button)
  );
  etr_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_db_pod (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_raw(raw.pod_button),
    .o_level(level.pod_button),
    .o_rise(rise.pod_button)
  );
  etr_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_db_tgt (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_raw(raw.target_board),
    .o_level(level.target_board),
    .o_rise(rise.target_board)
  );
  etr_debounce #(.STABLE_CYCLES(DEBOUNCE_LEN)) u_db_emu (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_raw(i_emu_reset_button),
    .o_level(),
    .o_rise(emu_btn_rise)
  );

  // ----------------------------------------
  // Emulator reset domain
  // ----------------------------------------
  etr_state_t state_reg;
  etr_state_t state_next;
  logic [CNT_W-1:0] init_cnt_reg;
  logic [CNT_W-1:0] init_cnt_next;
  wire logic in_clear = state_reg == ETR_ST_CLEAR;
  wire logic emu_ready = state_reg == ETR_ST_READY;
  wire logic init_done = init_cnt_reg >= CNT_W'(INIT_LEN - 1);
  // A press restarts the whole sequence, even halfway through a clear
  wire logic emu_restart = emu_btn_rise;

  // Counts clear cycles; held at zero outside the clear phase
  assign init_cnt_next = (in_clear && !init_done) ? init_cnt_reg + CNT_W'(1) : '0;

  // Button restarts the sequence; it never touches the core reset path
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ETR_ST_RESET: begin
        state_next = ETR_ST_CLEAR;
      end
      ETR_ST_CLEAR: begin
        if (init_done) begin
          state_next = ETR_ST_TEST;
        end
      end
      ETR_ST_TEST: begin
        if (i_self_test_pass) begin
          state_next = ETR_ST_READY;
        end
      end
      ETR_ST_READY: begin
        state_next = ETR_ST_READY;
      end
      default: begin
        state_next = ETR_ST_RESET;
      end
    endcase
    if (emu_restart) begin
      state_next = ETR_ST_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= ETR_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      init_cnt_reg <= '0;
    end else begin
      init_cnt_reg <= init_cnt_next;
    end
  end

  // ----------------------------------------
  // Emulated-core reset domain
  // ----------------------------------------
  // Gated part ignores the board reset unless the host enabled it
  wire logic tgt_allowed = !i_ext_reset_gated_part || i_host_ext_reset_en;
  wire logic panel_req = rise.panel_button && i_core_running;
  wire logic pod_req = rise.pod_button && i_core_running;
  wire logic tgt_req = rise.target_board && i_core_running && tgt_allowed;
  // Host command is taken whether the core runs or not
  wire logic host_req = i_host_reset_cmd;
  // Nothing is taken while the emulator itself is still initialising
  wire logic core_req = (panel_req || pod_req || tgt_req || host_req) && emu_ready;
  logic [CNT_W-1:0] core_cnt_reg;
  logic [CNT_W-1:0] core_cnt_next;
  logic core_rst_reg;
  logic core_rst_next;
  logic halt_reg;
  logic halt_next;
  logic tgt_out_reg;
  logic tgt_out_next;
  wire logic core_busy = core_cnt_reg != '0;

  // A request in mid-pulse reloads the count, so the pulse is stretched
  assign core_cnt_next = core_req ? CNT_W'(CORE_RST_LEN - 1) :
                         core_busy ? core_cnt_reg - CNT_W'(1) : '0;
  assign core_rst_next = core_req || core_busy;
  assign halt_next = emu_ready && i_host_reset_cmd && i_core_running;
  // Board reset stays asserted on the net while held and the core runs; buttons and host never reach it
  assign tgt_out_next = level.target_board && i_core_running && tgt_allowed;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      core_cnt_reg <= '0;
      core_rst_reg <= 1'b0;
    end else begin
      core_cnt_reg <= core_cnt_next;
      core_rst_reg <= core_rst_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      halt_reg <= 1'b0;
    end else begin
      halt_reg <= halt_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tgt_out_reg <= 1'b0;
    end else begin
      tgt_out_reg <= tgt_out_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic ready_reg;
  logic ready_next;
  logic clear_reg;
  logic clear_next;
  logic supply_reg;

  // Ready and clear look one state ahead so they change with the state register
  assign ready_next = state_next == ETR_ST_READY;
  assign clear_next = state_next == ETR_ST_CLEAR;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      clear_reg <= 1'b0;
    end else begin
      clear_reg <= clear_next;
    end
  end

  // Supply flag has no clearing path: it shows from the first clock on
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      supply_reg <= 1'b1;
    end else begin
      supply_reg <= 1'b1;
    end
  end

  assign o_supply_ok = supply_reg;
  assign o_ready = ready_reg;
  assign o_prog_mem_clear = clear_reg;
  assign o_core_reset = core_rst_reg;
  assign o_core_halt = halt_reg;
  assign o_target_reset_out = tgt_out_reg;
  assign o_target_reset_oe = tgt_out_reg;
endmodule

// >>> sim/etr_host_model.sv
// Host and target-side model: run state and self-test result
`timescale 1ns/1ps
module etr_host_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_run_req,
  input wire logic i_halt,
  input wire logic i_prog_mem_clear,
  output logic o_core_running,
  output logic o_self_test_pass
);
  // Cleared memory leaves nothing to run until the host reloads and restarts
  always_ff @(posedge i_clk) begin
    if (i_reset || i_halt || i_prog_mem_clear) begin
      o_core_running <= 1'b0;
    end else if (i_run_req) begin
      o_core_running <= 1'b1;
    end
    o_self_test_pass <= !i_reset && !i_prog_mem_clear;
  end
endmodule

// >>> sim/etr_reset_ctrl_asserts.sv
// Concurrent checks on the reset control ports
`timescale 1ns/1ps
module etr_reset_ctrl_asserts #(
  parameter int CORE_RST_LEN = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_host_reset_cmd,
  input wire logic i_core_running,
  input wire logic i_self_test_pass,
  input wire logic o_ready,
  input wire logic o_prog_mem_clear,
  input wire logic o_core_reset,
  input wire logic o_core_halt,
  input wire logic o_target_reset_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  host_rst_a: assert property (i_host_reset_cmd && o_ready |=> o_core_reset)
    else $error("host reset lost");
  run_halt_a: assert property (i_host_reset_cmd && o_ready && i_core_running
    |=> o_core_halt) else $error("no halt");
  halt_cause_a: assert property (o_core_halt |-> o_core_reset)
    else $error("halt without reset");
  domain_split_a: assert property (o_core_reset |-> !o_prog_mem_clear)
    else $error("domains crossed");
  clear_ready_a: assert property (o_prog_mem_clear |-> !o_ready)
    else $error("ready during clear");
  ready_test_a: assert property ($rose(o_ready) |-> $past(i_self_test_pass))
    else $error("ready before self test");
  pulse_len_a: assert property ($fell(o_core_reset) |-> $past(o_core_reset, CORE_RST_LEN))
    else $error("core reset short");
  net_run_a: assert property ($rose(o_target_reset_out) |-> $past(i_core_running))
    else $error("net driven while halted");
endmodule

bind etr_reset_ctrl etr_reset_ctrl_asserts #(.CORE_RST_LEN(CORE_RST_LEN)) u_chk (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_host_reset_cmd(i_host_reset_cmd),
  .i_core_running(i_core_running),
  .i_self_test_pass(i_self_test_pass),
  .o_ready(o_ready),
  .o_prog_mem_clear(o_prog_mem_clear),
  .o_core_reset(o_core_reset),
  .o_core_halt(o_core_halt),
  .o_target_reset_out(o_target_reset_out)
);

// >>> sim/etr_reset_ctrl_tb.sv
// Random and directed bench for the reset control block
`timescale 1ns/1ps
module etr_reset_ctrl_tb import etr_pkg::*; ;
  logic i_clk = 0, i_reset = 1, emu = 0, host = 0, en = 0, gated = 0, run = 0, hit = 0;
  etr_pins_t pins = '0;
  logic supply, ready, clr, core, halt, net, oe, running, pass;
  int errors = 0, samples_checked = 0, seed = 7369, n;
  always #4 i_clk = ~i_clk;
  etr_host_model u_host (.i_clk(i_clk), .i_reset(i_reset), .i_run_req(run), .i_halt(halt),
    .i_prog_mem_clear(clr), .o_core_running(running), .o_self_test_pass(pass));
  etr_reset_ctrl #(.INIT_LEN(8), .DEBOUNCE_LEN(4)) u_dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_emu_reset_button(emu), .i_back_panel_target_reset_button(pins.panel_button),
    .i_pod_reset_button(pins.pod_button), .i_target_reset(pins.target_board),
    .i_host_reset_cmd(host), .i_host_ext_reset_en(en), .i_ext_reset_gated_part(gated),
    .i_core_running(running), .i_self_test_pass(pass), .o_supply_ok(supply), .o_ready(ready),
    .o_prog_mem_clear(clr), .o_core_reset(core), .o_core_halt(halt),
    .o_target_reset_out(net), .o_target_reset_oe(oe));
  task automatic chk(string name, logic seen, logic exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Source 0 is the target board; only it depends on the gating option
  function automatic logic accepted(int s, logic run_st, logic gated_st, logic en_st);
    return run_st && (s != 0 || !gated_st || en_st);
  endfunction
  task automatic wait_ready;
    for (n = 0; n < 100 && ready !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (ready !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic set_run;
    @(posedge i_clk) run <= 1'b1;
    @(posedge i_clk) run <= 1'b0;
  endtask
  // Source 0 is the target board, the only one allowed onto the net
  task automatic press(int s, logic exp);
    repeat (1 + $unsigned($random(seed)) % 6) @(posedge i_clk);
    hit = 1'b0;
    pins[s] <= 1'b1;
    repeat (20) @(posedge i_clk) hit |= core;
    #1 chk("target net", net, exp & (s == 0));
    chk("net enable", oe, exp & (s == 0));
    @(posedge i_clk) pins[s] <= 1'b0;
    chk("core reset", hit, exp);
    repeat (30) @(posedge i_clk);
  endtask
  task automatic host_cmd(logic exp_halt);
    @(posedge i_clk) host <= 1'b1;
    @(posedge i_clk) host <= 1'b0;
    #1 chk("core reset", core, 1'b1);
    chk("halt", halt, exp_halt);
    chk("target net", net, 1'b0);
    repeat (20) @(posedge i_clk);
    #1 chk("core end", core, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    #1 chk("supply", supply, 1'b1);
    chk("ready", ready, 1'b0);
    wait_ready();
    for (int s = 0; s < 3; s++) begin
      set_run();
      press(s, accepted(s, 1'b1, gated, en));
      host_cmd(1'b1);
      press(s, accepted(s, 1'b0, gated, en));
      host_cmd(1'b0);
    end
    @(posedge i_clk) gated <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk) en <= (k < 2) ? k[0] : 1'($random(seed));
      set_run();
      press(0, accepted(0, 1'b1, gated, en));
      host_cmd(1'b1);
    end
    @(posedge i_clk) emu <= 1'b1;
    hit = 1'b0;
    #1;
    for (n = 0; n < 40 && clr !== 1'b1; n++) #8;
    chk("ready", ready, 1'b0);
    for (n = 0; n < 40 && clr === 1'b1; n++) #8 hit |= core;
    chk("clear length", n == 8, 1'b1);
    chk("core kept", hit, 1'b0);
    wait_ready();
    chk("ready back", ready, 1'b1);
    emu <= 1'b0;
    tally_and_finish();
  end
endmodule
